// >>> design/dac_ctrl_pkg.sv
// constants for the toggle / thermal / write-queue control block of a 40-channel dac.
// assumes one 40 MHz clock and a synchronous active-high reset at the user of this package.
//
// Function
// - select 00 plus code 001100 writes control
// - toggle enabled per eight-channel group bit
// - every channel owns an A and B register
// - B register loads only when group toggles
// - each load strobe of a toggling group alternates between A and B
// - first load after enabling shows A
// - load after disabling toggle shows A data
// - thermal shutdown only with monitor bit set
// - over-temperature powers down all output amplifiers
// - soft power-up while not over temperature, or monitor disable, restores outputs
// - write queue only with parallel interface
// - write-queue pin sampled once after reset
package dac_ctrl_pkg;

    // ------------------------------------------------------------
    // sizes
    // ------------------------------------------------------------
    localparam int NUM_CH = 40;
    localparam int NUM_GROUPS = 5;
    localparam int DAC_W = 12;
    localparam int ADDR_W = 8;
    localparam int DATA_W = 16;
    localparam int EVT_W = 2;

    // ------------------------------------------------------------
    // address layout: {register_select_hi, register_select_lo, channel_address_field}
    // ------------------------------------------------------------
    localparam int SEL_HI_POS = 7;
    localparam int SEL_LO_POS = 6;
    localparam int CHAN_MSB = 5;
    localparam int GROUP_LSB = 3;
    localparam logic [1:0] SEL_SPECIAL = 2'h0;
    localparam logic [1:0] SEL_B = 2'h2;
    localparam logic [1:0] SEL_A = 2'h3;
    localparam logic [5:0] CTRL_CODE = 6'h0C;
    localparam logic [5:0] PWRUP_CODE = 6'h09;
    localparam logic [5:0] STATUS_CODE = 6'h0D;
    localparam logic [5:0] MASK_CODE = 6'h0E;
    localparam logic [5:0] LAST_CHAN = 6'h27;

    // ------------------------------------------------------------
    // control register fields
    // ------------------------------------------------------------
    localparam int TOGGLE_LSB = 0;
    localparam int THERM_EN_POS = 6;
    localparam logic [15:0] CTRL_RST = 16'h0000;

    // ------------------------------------------------------------
    // status register fields (events sticky, live bits read only)
    // ------------------------------------------------------------
    localparam int EV_THERMAL = 0;
    localparam int EV_B_DROP = 1;
    localparam int ST_SHUTDOWN_POS = 8;
    localparam int ST_QUEUE_POS = 9;
    localparam logic [1:0] EVT_RST = 2'h0;
    localparam logic [1:0] MASK_RST = 2'h0;

    // ------------------------------------------------------------
    // init sequence
    // ------------------------------------------------------------
    typedef enum logic [0:0] {ST_INIT = 1'b0, ST_RUN = 1'b1} mode_t;

endpackage

// >>> design/dac_toggle_thermal_control.sv
// control logic: control register, A/B data registers, load strobe toggling,
// thermal shutdown and write-queue mode capture.
// assumes a host that issues one-cycle write/read strobes synchronous to clk,
// and an over-temperature comparator output already synchronous to clk.
//
// Decided for this implementation: strobed register access and the register addresses.
`timescale 1ns/10ps

module dac_toggle_thermal_control
(
    input wire logic clk, // 40 MHz clock
    input wire logic reset, // synchronous, active high
    input wire logic [dac_ctrl_pkg::ADDR_W-1:0] reg_addr, // select bits and channel field
    input wire logic [dac_ctrl_pkg::DATA_W-1:0] reg_wdata, // write data
    input wire logic reg_wr, // write strobe
    input wire logic reg_rd, // read strobe
    output logic [dac_ctrl_pkg::DATA_W-1:0] reg_rdata, // read data, cycle after reg_rd
    input wire logic output_load_strobe_n, // load strobe, falling edge acts
    input wire logic over_temp, // die above threshold
    input wire logic fifo_en, // write-queue enable pin
    input wire logic parallel_sel, // parallel interface selected
    output logic [dac_ctrl_pkg::NUM_CH*dac_ctrl_pkg::DAC_W-1:0] dac_out, // codes to the converters
    output logic amps_down, // output amplifiers powered down
    output logic write_queue_on, // write-queue mode active
    output logic irq // unmasked status bit set
);
    import dac_ctrl_pkg::*;

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    typedef struct packed {
        mode_t mode;
        logic [DATA_W-1:0] ctrl;
        logic [NUM_CH-1:0][DAC_W-1:0] a_reg;
        logic [NUM_CH-1:0][DAC_W-1:0] b_reg;
        logic [NUM_CH-1:0][DAC_W-1:0] dac;
        logic [NUM_GROUPS-1:0] phase;
        logic shutdown;
        logic queue_mode;
        logic strobe_prev;
        logic [EVT_W-1:0] status;
        logic [EVT_W-1:0] mask;
        logic [DATA_W-1:0] rdata;
    } state_t;

    state_t state_r;
    state_t state_nxt;
    logic strobe_fall;
    logic ctrl_wr;

    function automatic logic reg_hit(input logic [ADDR_W-1:0] addr, input logic [1:0] sel,
                                     input logic [5:0] code);
        reg_hit = (addr[SEL_HI_POS:SEL_LO_POS] == sel) && (addr[CHAN_MSB:0] == code);
    endfunction

    function automatic logic chan_hit(input logic [ADDR_W-1:0] addr, input logic [1:0] sel);
        chan_hit = (addr[SEL_HI_POS:SEL_LO_POS] == sel) && (addr[CHAN_MSB:0] <= LAST_CHAN);
    endfunction

    // detector leaves reset high, so a strobe held low through reset is taken as a fall in the first cycle after reset
    assign strobe_fall = state_r.strobe_prev & ~output_load_strobe_n;
    assign ctrl_wr = reg_wr && reg_hit(reg_addr, SEL_SPECIAL, CTRL_CODE);

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb
    begin
        logic [EVT_W-1:0] events;
        logic [5:0] ch;
        logic [2:0] grp;
        logic trip;
        state_nxt = state_r;
        events = '0;
        ch = reg_addr[CHAN_MSB:0];
        grp = reg_addr[CHAN_MSB:GROUP_LSB];
        trip = state_r.ctrl[THERM_EN_POS] & over_temp;
        state_nxt.rdata = '0;
        state_nxt.strobe_prev = output_load_strobe_n;

        // pin caught once
        // the pin is looked at only in the first cycle after reset, later changes are ignored
        if (state_r.mode == ST_INIT)
        begin
            state_nxt.queue_mode = fifo_en & parallel_sel;
            state_nxt.mode = ST_RUN;
        end

        // strobe alternates
        // strobe uses the registers as they stood before any write in the same cycle
        if (strobe_fall)
        begin
            for (int c = 0; c < NUM_CH; c++)
            begin
                if (state_r.ctrl[TOGGLE_LSB + c / 8] && state_r.phase[c / 8])
                    state_nxt.dac[c] = state_r.b_reg[c];
                else
                    state_nxt.dac[c] = state_r.a_reg[c];
            end
            for (int g = 0; g < NUM_GROUPS; g++)
            begin
                state_nxt.phase[g] = state_r.ctrl[TOGGLE_LSB + g] ? ~state_r.phase[g] : 1'b0;
            end
        end

        if (reg_wr)
        begin
            if (ctrl_wr)
            begin
                state_nxt.ctrl = reg_wdata;
                // per-group enable
                // any change of a group enable restarts that group on A
                for (int g = 0; g < NUM_GROUPS; g++)
                begin
                    if (reg_wdata[TOGGLE_LSB + g] != state_r.ctrl[TOGGLE_LSB + g])
                        state_nxt.phase[g] = 1'b0;
                end
            end
            // soft power-up
            // ignored while still hot, the shutdown would only trip again
            if (reg_hit(reg_addr, SEL_SPECIAL, PWRUP_CODE) && !over_temp)
                state_nxt.shutdown = 1'b0;
            if (reg_hit(reg_addr, SEL_SPECIAL, STATUS_CODE))
                state_nxt.status = state_r.status & ~reg_wdata[EVT_W-1:0];
            if (reg_hit(reg_addr, SEL_SPECIAL, MASK_CODE))
                state_nxt.mask = reg_wdata[EVT_W-1:0];
            if (chan_hit(reg_addr, SEL_A))
                state_nxt.a_reg[ch] = reg_wdata[DAC_W-1:0];
            if (chan_hit(reg_addr, SEL_B))
            begin
                if (state_r.ctrl[TOGGLE_LSB + int'(grp)])
                    state_nxt.b_reg[ch] = reg_wdata[DAC_W-1:0];
                else
                    events[EV_B_DROP] = 1'b1;
            end
        end

        if (!state_r.ctrl[THERM_EN_POS])
            state_nxt.shutdown = 1'b0;
        else if (trip)
        begin
            events[EV_THERMAL] = !state_r.shutdown;
            state_nxt.shutdown = 1'b1;
        end

        // a new event wins over a clear in the same cycle
        state_nxt.status = state_nxt.status | events;

        if (reg_rd)
        begin
            case (reg_addr[SEL_HI_POS:SEL_LO_POS])
                SEL_SPECIAL:
                begin
                    if (ch == CTRL_CODE)
                        state_nxt.rdata = state_r.ctrl;
                    else if (ch == STATUS_CODE)
                    begin
                        state_nxt.rdata[EVT_W-1:0] = state_r.status;
                        state_nxt.rdata[ST_SHUTDOWN_POS] = state_r.shutdown;
                        state_nxt.rdata[ST_QUEUE_POS] = state_r.queue_mode;
                    end
                    else if (ch == MASK_CODE)
                        state_nxt.rdata[EVT_W-1:0] = state_r.mask;
                end
                SEL_A:
                begin
                    if (ch <= LAST_CHAN)
                        state_nxt.rdata[DAC_W-1:0] = state_r.a_reg[ch];
                end
                SEL_B:
                begin
                    if (ch <= LAST_CHAN)
                        state_nxt.rdata[DAC_W-1:0] = state_r.b_reg[ch];
                end
                default:
                begin
                    state_nxt.rdata = '0;
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            state_r <= '0;
            state_r.mode <= ST_INIT;
            state_r.ctrl <= CTRL_RST;
            state_r.status <= EVT_RST;
            state_r.mask <= MASK_RST;
            state_r.strobe_prev <= 1'b1;
        end
        else
        begin
            state_r <= state_nxt;
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    assign reg_rdata = state_r.rdata;
    assign dac_out = state_r.dac;
    assign amps_down = state_r.shutdown;
    assign write_queue_on = state_r.queue_mode;
    assign irq = |(state_r.status & state_r.mask);

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (reset);

    sequence s_load_toggle_g0;
        strobe_fall && state_r.ctrl[TOGGLE_LSB] && !ctrl_wr;
    endsequence

    sequence s_load_plain_g0;
        strobe_fall && !state_r.ctrl[TOGGLE_LSB];
    endsequence

    sequence s_hot_trip;
        state_r.ctrl[THERM_EN_POS] && over_temp;
    endsequence

    // data checks watch group 0 only; every group runs through the same loop
    a_ctrl_decode: assert property (ctrl_wr |=> state_r.ctrl == $past(reg_wdata))
        else $error("control write not decoded");

    a_phase_restart: assert property (ctrl_wr && reg_wdata[TOGGLE_LSB] != state_r.ctrl[TOGGLE_LSB]
        |=> !state_r.phase[0])
        else $error("toggle enable change did not restart on A");

    a_b_load_gate: assert property (reg_wr && reg_addr == {SEL_B, 6'h00} && state_r.ctrl[TOGGLE_LSB]
        |=> state_r.b_reg[0] == $past(reg_wdata[DAC_W-1:0]))
        else $error("B register load lost");

    a_b_drop_write: assert property (reg_wr && reg_addr == {SEL_B, 6'h00} && !state_r.ctrl[TOGGLE_LSB]
        |=> $stable(state_r.b_reg[0]) && state_r.status[EV_B_DROP])
        else $error("B register changed while toggle off");

    a_toggle_flip: assert property (s_load_toggle_g0
        |=> state_r.phase[0] != $past(state_r.phase[0])
        && state_r.dac[0] == ($past(state_r.phase[0]) ? $past(state_r.b_reg[0]) : $past(state_r.a_reg[0])))
        else $error("load strobe did not alternate");

    // only the strobe right after an enable is checked here; later ones fall to a_toggle_flip
    a_first_load_a: assert property ($rose(state_r.ctrl[TOGGLE_LSB]) ##0 !strobe_fall
        ##1 s_load_toggle_g0 |=> state_r.dac[0] == $past(state_r.a_reg[0]))
        else $error("first load after enable not from A");

    a_plain_load_a: assert property (s_load_plain_g0
        |=> state_r.dac[0] == $past(state_r.a_reg[0]) && !state_r.phase[0])
        else $error("load with toggle off not from A");

    a_thermal_trip: assert property (s_hot_trip |=> amps_down)
        else $error("amplifiers not powered down on over-temperature");

    // a first trip must leave its event even when software clears status in the same cycle
    a_thermal_event: assert property (s_hot_trip ##0 !amps_down |=> state_r.status[EV_THERMAL])
        else $error("thermal shutdown event not recorded");

    a_monitor_off: assert property (!state_r.ctrl[THERM_EN_POS] |=> !amps_down)
        else $error("shutdown while monitor disabled");

    // shutdown stands until a soft power-up or the monitor is switched off
    a_shutdown_holds: assert property (amps_down && state_r.ctrl[THERM_EN_POS]
        && !(reg_wr && reg_hit(reg_addr, SEL_SPECIAL, PWRUP_CODE)) |=> amps_down)
        else $error("shutdown released without a restore");

    a_power_up: assert property (amps_down && reg_wr && reg_hit(reg_addr, SEL_SPECIAL, PWRUP_CODE)
        && !over_temp |=> !amps_down)
        else $error("soft power-up did not restore outputs");

    a_queue_capture: assert property (state_r.mode == ST_INIT
        |=> write_queue_on == $past(fifo_en && parallel_sel) ##1 $stable(write_queue_on))
        else $error("write-queue mode not captured once");

    // the pin is never looked at again until the next reset
    a_queue_steady: assert property (state_r.mode == ST_RUN |=> $stable(write_queue_on))
        else $error("write-queue mode changed after init");

    a_queue_parallel: assert property (state_r.mode == ST_INIT && !parallel_sel |=> !write_queue_on)
        else $error("write-queue mode without parallel interface");

    // read data stands for one cycle only, so a stale word is never taken twice
    a_read_idle: assert property (!reg_rd |=> reg_rdata == '0)
        else $error("read data outside its cycle");

endmodule

// >>> sim/host_model.sv
// host model: drives the register port and the load strobe of the control block.
// assumes the block samples every input on the rising edge of clk and never stalls.
`timescale 1ns/10ps

module host_model
(
    input wire logic clk, // bench clock
    input wire logic [dac_ctrl_pkg::DATA_W-1:0] reg_rdata, // read data from the block
    output logic [dac_ctrl_pkg::ADDR_W-1:0] reg_addr, // select bits and channel field
    output logic [dac_ctrl_pkg::DATA_W-1:0] reg_wdata, // write data
    output logic reg_wr, // write strobe
    output logic reg_rd, // read strobe
    output logic load_n // load strobe, active low
);
    import dac_ctrl_pkg::*;

    initial
    begin
        reg_addr = 8'h00;
        reg_wdata = 16'h0000;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        load_n = 1'b1;
    end

    // idle bus shows the inverse so a stale value never looks valid
    task automatic idle();
        reg_addr <= ~reg_addr;
        reg_wdata <= ~reg_wdata;
    endtask

    // one-cycle writes, bench keeps the setup order
    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        @(posedge clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
        idle();
    endtask

    task automatic rd(input logic [7:0] a, output logic [15:0] d);
        @(posedge clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        idle();
        #1;
        d = reg_rdata;
    endtask

    // strobe only after the registers are loaded
    task automatic ld();
        @(posedge clk);
        load_n <= 1'b0;
        @(posedge clk);
        load_n <= 1'b1;
        repeat (2) @(posedge clk);
        #1;
    endtask
endmodule

// >>> sim/tb_top.sv
// self-checking bench: toggle groups, A/B loads, thermal shutdown and write-queue capture.
// assumes the host model in host_model.sv and the package dac_ctrl_pkg.
`timescale 1ns/10ps

module tb_top;
    import dac_ctrl_pkg::*;

    logic clk = 1'b0;
    logic reset = 1'b1;
    logic over_temp = 1'b0;
    logic fifo_en = 1'b1;
    logic parallel_sel = 1'b0;
    logic [ADDR_W-1:0] reg_addr;
    logic [DATA_W-1:0] reg_wdata;
    logic [DATA_W-1:0] reg_rdata;
    logic reg_wr;
    logic reg_rd;
    logic load_n;
    logic [NUM_CH*DAC_W-1:0] dac_out;
    logic amps_down;
    logic write_queue_on;
    logic irq;
    int mismatches = 0;
    int num_checks = 0;

    always #12.5 clk = ~clk;

    dac_toggle_thermal_control dac_toggle_thermal_control_inst (.clk(clk), .reset(reset), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .output_load_strobe_n(load_n), .over_temp(over_temp), .fifo_en(fifo_en), .parallel_sel(parallel_sel),
        .dac_out(dac_out), .amps_down(amps_down), .write_queue_on(write_queue_on), .irq(irq));

    host_model host_model_inst (.clk(clk), .reg_rdata(reg_rdata), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .load_n(load_n));

    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        num_checks++;
        if (seen !== exp)
        begin
            mismatches++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    function automatic logic [15:0] ch(input int c);
        return {4'h0, dac_out[c*DAC_W +: DAC_W]};
    endfunction

    task automatic do_reset();
        @(posedge clk);
        reset <= 1'b1;
        repeat (4) @(posedge clk);
        reset <= 1'b0;
        repeat (2) @(posedge clk);
        #1;
    endtask

    task automatic settle();
        repeat (2) @(posedge clk);
        #1;
    endtask

    task automatic final_report();
        $display("checks %0d mismatches %0d", num_checks, mismatches);
        if (mismatches == 0 && num_checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    initial
    begin
        #2000000;
        mismatches++;
        final_report();
    end

    initial
    begin
        logic [15:0] d;
        do_reset();
        chk(write_queue_on, 16'h0000);
        chk(ch(0), 16'h0000);
        chk(irq, 16'h0000);
        host_model_inst.rd(8'h0C, d);
        chk(d, 16'h0000);
        @(posedge clk) parallel_sel <= 1'b1;
        do_reset();
        chk(write_queue_on, 16'h0001);
        @(posedge clk) fifo_en <= 1'b0;
        settle();
        chk(write_queue_on, 16'h0001);
        do_reset();
        chk(write_queue_on, 16'h0000);
        @(posedge clk) fifo_en <= 1'b1;
        do_reset();
        chk(write_queue_on, 16'h0001);
        $display("test init done");

        host_model_inst.wr(8'h0C, 16'h0003);
        host_model_inst.rd(8'h0C, d);
        chk(d, 16'h0003);
        host_model_inst.wr(8'hC0, 16'h0111);
        host_model_inst.wr(8'hC8, 16'h0222);
        host_model_inst.wr(8'hD0, 16'h0333);
        host_model_inst.wr(8'hE7, 16'h0777);
        host_model_inst.wr(8'h80, 16'h0AAA);
        host_model_inst.wr(8'h88, 16'h0BBB);
        host_model_inst.wr(8'h90, 16'h0CCC);
        host_model_inst.rd(8'h80, d);
        chk(d, 16'h0AAA);
        host_model_inst.rd(8'h90, d);
        chk(d, 16'h0000);
        host_model_inst.rd(8'h0D, d);
        chk(d, 16'h0202);
        chk(irq, 16'h0000);
        host_model_inst.ld();
        chk(ch(0), 16'h0111);
        chk(ch(39), 16'h0777);
        host_model_inst.ld();
        chk(ch(0), 16'h0AAA);
        chk(ch(8), 16'h0BBB);
        chk(ch(16), 16'h0333);
        host_model_inst.ld();
        chk(ch(8), 16'h0222);
        host_model_inst.ld();
        host_model_inst.wr(8'h0C, 16'h0000);
        host_model_inst.ld();
        chk(ch(0), 16'h0111);
        host_model_inst.ld();
        chk(ch(0), 16'h0111);
        host_model_inst.wr(8'h80, 16'h0555);
        host_model_inst.rd(8'h80, d);
        chk(d, 16'h0AAA);
        host_model_inst.wr(8'h0C, 16'h0001);
        host_model_inst.ld();
        chk(ch(0), 16'h0111);
        host_model_inst.ld();
        chk(ch(0), 16'h0AAA);
        $display("test toggle done");

        host_model_inst.wr(8'h0D, 16'h0003);
        @(posedge clk) over_temp <= 1'b1;
        settle();
        chk(amps_down, 16'h0000);
        host_model_inst.wr(8'h0E, 16'h0001);
        host_model_inst.wr(8'h0C, 16'h0040);
        settle();
        chk(amps_down, 16'h0001);
        chk(irq, 16'h0001);
        host_model_inst.rd(8'h0D, d);
        chk(d, 16'h0301);
        host_model_inst.rd(8'h0E, d);
        chk(d, 16'h0001);
        host_model_inst.wr(8'h09, 16'h0000);
        settle();
        chk(amps_down, 16'h0001);
        @(posedge clk) over_temp <= 1'b0;
        host_model_inst.wr(8'h09, 16'h0000);
        settle();
        chk(amps_down, 16'h0000);
        host_model_inst.wr(8'h0D, 16'h0001);
        settle();
        chk(irq, 16'h0000);
        @(posedge clk) over_temp <= 1'b1;
        settle();
        chk(amps_down, 16'h0001);
        host_model_inst.wr(8'h0C, 16'h0000);
        settle();
        chk(amps_down, 16'h0000);
        @(posedge clk) over_temp <= 1'b0;
        $display("test thermal done");
        final_report();
    end
endmodule
